// ===== design/cfg_bank_regs.svh
/*
  Constants for the command/status and window base configuration registers:
  offsets, field positions, fixed values and reset values.
  Assumes it is included by bare name from design files that use it.
*/
// Function
// - Set abort flags on abort events
// - Flags stay until written one
// - Select speed reads fixed medium code
// - Target fast chaining reads one, accepted
// - Initiator fast chaining reads zero always
// - Address stepping reads one, two-cycle drive
// - Snoop captures palette writes without claiming
// - Palette writes ignored unless legacy enabled
// - No bus request unless initiator allowed
// - Claim window only with memory decode
// - I/O enable zero, never answer
// - Command/status resets to 028000A0
// - Only top five base bits writable
// - Prefetch safe bit reads one
// - Reads return all lanes, merges accepted
// - Window type bit reads zero
// - Window base resets to 00000008
// - Reserved bits read zero, writes ignored
// - ROM decode needs both enables set
`ifndef CFG_BANK_REGS_SVH
`define CFG_BANK_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte address in configuration space)
// ----------------------------------------------------------------
`define CFG_COMMAND_STATUS_OFS 8'h04
`define CFG_WINDOW_BASE_OFS 8'h10

// ----------------------------------------------------------------
// Command/status fields
// ----------------------------------------------------------------
`define CS_INITIATOR_ABORT_BIT 29
`define CS_COMPLETER_ABORT_BIT 28
`define CS_SELECT_SPEED_HI 26
`define CS_SELECT_SPEED_LO 25
`define CS_SELECT_SPEED_CODE 2'h1
`define CS_TARGET_FAST_BIT 23
`define CS_INITIATOR_FAST_BIT 9
`define CS_ADDR_STEP_BIT 7
`define CS_PALETTE_SNOOP_BIT 5
`define CS_INITIATOR_ALLOW_BIT 2
`define CS_MEMORY_DECODE_BIT 1
`define CS_IO_ENABLE_BIT 0
`define CS_RESET_VALUE 32'h028000A0

// ----------------------------------------------------------------
// Window base fields
// ----------------------------------------------------------------
`define WB_BASE_HI 31
`define WB_BASE_LO 27
`define WB_BASE_W 5
`define WB_PREFETCH_BIT 3
`define WB_TYPE_BIT 0
`define WB_RESET_VALUE 32'h00000008

// ----------------------------------------------------------------
// Byte lanes, abort flag count and zero word
// ----------------------------------------------------------------
`define LANE_LOW 0
`define LANE_TOP 3
`define ABORT_FLAG_COUNT 2
`define ZERO_WORD 32'h00000000

`endif

// ===== design/cfg_bank_pkg.sv
/*
  Types shared by the configuration register bank and its helpers.
  Assumes nothing of its surroundings.
*/
package cfg_bank_pkg;

  typedef logic [31:0] word_t;
  typedef logic [4:0] base_bits_t;

endpackage

// ===== design/abort_flag_bank.sv
/*
  Sticky abort flags, set by hardware events and cleared by writing one.
  Assumes set pulses and clear strobes are on i_clk, one cycle each.
*/
`timescale 1ns/1ns
`include "cfg_bank_regs.svh"

module abort_flag_bank (
  input wire logic i_clk,                                 // Core clock
  input wire logic i_sys_rst,                             // Sync reset, high
  input wire logic i_clk_en,                              // Freezes state when low
  input wire logic [`ABORT_FLAG_COUNT-1:0] i_set,         // Abort event pulses
  input wire logic [`ABORT_FLAG_COUNT-1:0] i_clear,       // Write-one clear strobes
  output logic [`ABORT_FLAG_COUNT-1:0] o_flags            // Flag levels
);

  // ----------------------------------------------------------------
  // One flag per bit; set wins over a clear in the same cycle
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `ABORT_FLAG_COUNT; g = g + 1)
    begin : g_flag
      logic flag_q;
      logic flag_d;
      assign flag_d = i_set[g] | (flag_q & ~i_clear[g]);
      always_ff @(posedge i_clk)
      begin
        if (i_sys_rst)
          flag_q <= 1'b0;
        else if (i_clk_en)
          flag_q <= flag_d;
      end
      assign o_flags[g] = flag_q;
    end
  endgenerate

endmodule

// ===== design/window_decode.sv
/*
  Decides which accesses the device claims: memory window, expansion ROM,
  legacy palette writes, I/O and bus requests. All outputs are registered.
  Assumes all requests are qualified one-cycle levels on i_clk.
*/
`timescale 1ns/1ns
`include "cfg_bank_regs.svh"

module window_decode (
  input wire logic i_clk,                         // Core clock
  input wire logic i_sys_rst,                     // Sync reset, high
  input wire logic i_clk_en,                      // Freezes state when low
  input wire logic i_memory_decode_on,            // Memory decode enable
  input wire logic i_initiator_allow,             // Bus mastering enable
  input wire logic i_palette_snoop,               // Snoop mode
  input wire cfg_bank_pkg::base_bits_t i_base,    // Window base bits
  input wire logic i_legacy_video_en,             // Redirect register enable
  input wire logic i_rom_decode_en,               // ROM decode enable
  input wire logic i_mem_req,                     // Memory access present
  input wire logic [31:0] i_mem_addr,             // Memory access address
  input wire logic i_rom_hit,                     // Access falls in ROM window
  input wire logic i_io_req,                      // I/O access present
  input wire logic i_palette_wr,                  // Legacy palette write present
  input wire logic [7:0] i_palette_wdata,         // Palette write data
  input wire logic i_dma_want,                    // Engine wants the bus
  output logic o_mem_claim,                       // Claim memory access
  output logic o_rom_claim,                       // Claim ROM access
  output logic o_io_claim,                        // Claim I/O access
  output logic o_palette_claim,                   // Claim palette write
  output logic o_palette_take,                    // Palette data taken
  output logic [7:0] o_palette_data,              // Taken palette data
  output logic o_bus_req                          // Bus ownership request
);

  wire logic window_hit;
  wire logic mem_claim_d;
  wire logic rom_claim_d;
  wire logic palette_live;
  wire logic palette_claim_d;
  wire logic bus_req_d;

  // ----------------------------------------------------------------
  // Decode terms
  // ----------------------------------------------------------------
  assign window_hit = (i_mem_addr[`WB_BASE_HI:`WB_BASE_LO] == i_base);
  assign mem_claim_d = i_mem_req & window_hit & i_memory_decode_on;
  assign rom_claim_d = i_rom_hit & i_rom_decode_en & i_memory_decode_on;
  assign palette_live = i_palette_wr & i_legacy_video_en;
  assign palette_claim_d = palette_live & ~i_palette_snoop;
  assign bus_req_d = i_dma_want & i_initiator_allow;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_mem_claim <= 1'b0;
      o_rom_claim <= 1'b0;
      o_io_claim <= 1'b0;
      o_palette_claim <= 1'b0;
      o_palette_take <= 1'b0;
      o_palette_data <= 8'h00;
      o_bus_req <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_mem_claim <= mem_claim_d;
      o_rom_claim <= rom_claim_d;
      o_io_claim <= 1'b0;
      o_palette_claim <= palette_claim_d;
      o_palette_take <= palette_live;
      if (palette_live)
        o_palette_data <= i_palette_wdata;
      o_bus_req <= bus_req_d;
    end
  end

endmodule

// ===== design/pci_cfg_command_and_base.sv
/*
  Command/status and window base configuration registers, with the decode
  and abort bookkeeping they steer.
  Assumes the transaction engine presents configuration accesses, abort
  events and decode requests as single-cycle signals on i_clk.
*/
`timescale 1ns/1ns
`include "cfg_bank_regs.svh"

module pci_cfg_command_and_base (
  input wire logic i_clk,                         // Core clock, 250 MHz
  input wire logic i_sys_rst,                     // Sync reset, high
  input wire logic i_clk_en,                      // Freezes state when low
  input wire logic i_cfg_req,                     // Configuration access strobe
  input wire logic i_cfg_we,                      // 1 write, 0 read
  input wire logic [7:0] i_cfg_addr,              // Configuration byte address
  input wire logic [3:0] i_cfg_be,                // Byte enables, high
  input wire cfg_bank_pkg::word_t i_cfg_wdata,    // Write data
  input wire logic i_initiator_abort_evt,         // Master abort issued
  input wire logic i_completer_abort_evt,         // Target abort detected
  input wire logic i_legacy_video_en,             // Redirect register enable
  input wire logic i_rom_decode_en,               // ROM decode enable
  input wire logic i_mem_req,                     // Memory access present
  input wire logic [31:0] i_mem_addr,             // Memory access address
  input wire logic i_rom_hit,                     // Access in ROM window
  input wire logic i_io_req,                      // I/O access present
  input wire logic i_palette_wr,                  // Legacy palette write
  input wire logic [7:0] i_palette_wdata,         // Palette write data
  input wire logic i_dma_want,                    // Engine wants the bus
  output cfg_bank_pkg::word_t o_cfg_rdata,        // Read data
  output logic o_cfg_ack,                         // Access done pulse
  output logic o_mem_claim,                       // Claim memory access
  output logic o_rom_claim,                       // Claim ROM access
  output logic o_io_claim,                        // Claim I/O access
  output logic o_palette_claim,                   // Claim palette write
  output logic o_palette_take,                    // Palette data taken
  output logic [7:0] o_palette_data,              // Taken palette data
  output logic o_bus_req,                         // Bus ownership request
  output logic o_read_all_lanes,                  // Reads return all lanes
  output logic o_target_fast_chain_ok,            // Accept fast back-to-back
  output logic o_initiator_fast_chain_en,         // Issue fast back-to-back
  output logic o_address_stepping                 // Two-cycle address drive
);

  // ----------------------------------------------------------------
  // Writable state
  // ----------------------------------------------------------------
  logic palette_snoop_q;
  logic initiator_allow_q;
  logic memory_decode_on_q;
  cfg_bank_pkg::base_bits_t window_base_q;
  logic [`ABORT_FLAG_COUNT-1:0] abort_flags;

  // Reset words as constants so their fields can be selected
  localparam cfg_bank_pkg::word_t cs_reset_word = `CS_RESET_VALUE;
  localparam cfg_bank_pkg::word_t wb_reset_word = `WB_RESET_VALUE;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  wire logic sel_cs;
  wire logic sel_wb;
  wire logic wr_cs_low;
  wire logic wr_cs_top;
  wire logic wr_wb_top;
  wire logic [`ABORT_FLAG_COUNT-1:0] abort_set;
  wire logic [`ABORT_FLAG_COUNT-1:0] abort_clear;
  wire cfg_bank_pkg::word_t cs_view;
  wire cfg_bank_pkg::word_t wb_view;
  wire cfg_bank_pkg::word_t rdata_d;

  assign sel_cs = i_cfg_req & (i_cfg_addr == `CFG_COMMAND_STATUS_OFS);
  assign sel_wb = i_cfg_req & (i_cfg_addr == `CFG_WINDOW_BASE_OFS);
  assign wr_cs_low = sel_cs & i_cfg_we & i_cfg_be[`LANE_LOW];
  assign wr_cs_top = sel_cs & i_cfg_we & i_cfg_be[`LANE_TOP];
  assign wr_wb_top = sel_wb & i_cfg_we & i_cfg_be[`LANE_TOP];

  assign abort_set = {i_initiator_abort_evt, i_completer_abort_evt};
  assign abort_clear = {wr_cs_top & i_cfg_wdata[`CS_INITIATOR_ABORT_BIT],
                        wr_cs_top & i_cfg_wdata[`CS_COMPLETER_ABORT_BIT]};

  // ----------------------------------------------------------------
  // Read views; fixed fields are wired, reserved bits are zero
  // ----------------------------------------------------------------
  function automatic cfg_bank_pkg::word_t build_cs(
    input logic [`ABORT_FLAG_COUNT-1:0] flags,
    input logic snoop,
    input logic allow,
    input logic mem_on
  );
    cfg_bank_pkg::word_t v;
    v = `ZERO_WORD;
    v[`CS_INITIATOR_ABORT_BIT] = flags[1];
    v[`CS_COMPLETER_ABORT_BIT] = flags[0];
    v[`CS_SELECT_SPEED_HI:`CS_SELECT_SPEED_LO] = `CS_SELECT_SPEED_CODE;
    v[`CS_TARGET_FAST_BIT] = 1'b1;
    v[`CS_INITIATOR_FAST_BIT] = 1'b0;
    v[`CS_ADDR_STEP_BIT] = 1'b1;
    v[`CS_PALETTE_SNOOP_BIT] = snoop;
    v[`CS_INITIATOR_ALLOW_BIT] = allow;
    v[`CS_MEMORY_DECODE_BIT] = mem_on;
    v[`CS_IO_ENABLE_BIT] = 1'b0;
    return v;
  endfunction

  assign cs_view = build_cs(abort_flags, palette_snoop_q, initiator_allow_q,
                            memory_decode_on_q);
  assign wb_view = {window_base_q, 23'h000000, 1'b1, 2'h0, 1'b0};
  assign rdata_d = sel_cs ? cs_view : (sel_wb ? wb_view : `ZERO_WORD);

  // ----------------------------------------------------------------
  // Abort flags
  // ----------------------------------------------------------------
  abort_flag_bank u_abort (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_set(abort_set),
    .i_clear(abort_clear),
    .o_flags(abort_flags)
  );

  // ----------------------------------------------------------------
  // Writable fields and reset values
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      palette_snoop_q <= cs_reset_word[`CS_PALETTE_SNOOP_BIT];
      initiator_allow_q <= cs_reset_word[`CS_INITIATOR_ALLOW_BIT];
      memory_decode_on_q <= cs_reset_word[`CS_MEMORY_DECODE_BIT];
    end
    else if (i_clk_en && wr_cs_low)
    begin
      palette_snoop_q <= i_cfg_wdata[`CS_PALETTE_SNOOP_BIT];
      initiator_allow_q <= i_cfg_wdata[`CS_INITIATOR_ALLOW_BIT];
      memory_decode_on_q <= i_cfg_wdata[`CS_MEMORY_DECODE_BIT];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      window_base_q <= wb_reset_word[`WB_BASE_HI:`WB_BASE_LO];
    else if (i_clk_en && wr_wb_top)
      window_base_q <= i_cfg_wdata[`WB_BASE_HI:`WB_BASE_LO];
  end

  // ----------------------------------------------------------------
  // Configuration answer: one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_cfg_rdata <= `ZERO_WORD;
      o_cfg_ack <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_cfg_ack <= i_cfg_req;
      if (i_cfg_req && !i_cfg_we)
        o_cfg_rdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Fixed capability levels toward the transaction engine
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_read_all_lanes <= 1'b1;
      o_target_fast_chain_ok <= 1'b1;
      o_initiator_fast_chain_en <= 1'b0;
      o_address_stepping <= 1'b1;
    end
    else if (i_clk_en)
    begin
      o_read_all_lanes <= 1'b1;
      o_target_fast_chain_ok <= 1'b1;
      o_initiator_fast_chain_en <= 1'b0;
      o_address_stepping <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Access decode steered by the registers
  // ----------------------------------------------------------------
  window_decode u_decode (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_memory_decode_on(memory_decode_on_q),
    .i_initiator_allow(initiator_allow_q),
    .i_palette_snoop(palette_snoop_q),
    .i_base(window_base_q),
    .i_legacy_video_en(i_legacy_video_en),
    .i_rom_decode_en(i_rom_decode_en),
    .i_mem_req(i_mem_req),
    .i_mem_addr(i_mem_addr),
    .i_rom_hit(i_rom_hit),
    .i_io_req(i_io_req),
    .i_palette_wr(i_palette_wr),
    .i_palette_wdata(i_palette_wdata),
    .i_dma_want(i_dma_want),
    .o_mem_claim(o_mem_claim),
    .o_rom_claim(o_rom_claim),
    .o_io_claim(o_io_claim),
    .o_palette_claim(o_palette_claim),
    .o_palette_take(o_palette_take),
    .o_palette_data(o_palette_data),
    .o_bus_req(o_bus_req)
  );

endmodule

// ===== tb/cfg_host_model.sv
/*
  Host bridge model: issues single configuration accesses to the bank.
  Assumes the bank acks one cycle after each strobe, with read data.
*/
`timescale 1ns/1ns

module cfg_host_model (
  input wire logic i_clk, // Clock
  input wire logic i_ack, // Access done
  input wire cfg_bank_pkg::word_t i_rdata, // Read data
  output logic o_req, // Strobe
  output logic o_we, // Write
  output logic [7:0] o_addr, // Address
  output logic [3:0] o_be, // Byte enables
  output cfg_bank_pkg::word_t o_wdata // Write data
);
  initial
  begin
    {o_req, o_we, o_addr, o_be} = 14'h0000;
    o_wdata = 32'h00000000;
  end

  // One strobe after a host delay; idle lines are scrambled afterwards
  task automatic access(input logic we, input logic [7:0] a, input logic [3:0] be,
      input cfg_bank_pkg::word_t wd, input int gap, output cfg_bank_pkg::word_t rd,
      output logic ack);
    repeat (gap + 1) @(negedge i_clk);
    {o_req, o_we, o_addr, o_be} = {1'h1, we, a, be};
    o_wdata = wd;
    @(negedge i_clk);
    ack = i_ack;
    rd = i_rdata;
    {o_req, o_we, o_addr, o_be} = {1'h0, ~we, ~a, ~be};
    o_wdata = ~wd;
  endtask
endmodule

// ===== tb/cfg_bank_asserts.sv
/*
  Port checker for the command/status and window base bank.
  Assumes it is bound into every instance of the bank's top module.
*/
`timescale 1ns/1ns

module cfg_bank_asserts (
  input wire logic i_clk, // Clock
  input wire logic i_sys_rst, // Reset
  input wire logic i_clk_en, // Enable
  input wire logic i_cfg_req, // Strobe
  input wire logic i_cfg_we, // Write
  input wire logic i_legacy_video_en, // Legacy enable
  input wire logic i_rom_decode_en, // ROM enable
  input wire logic i_mem_req, // Memory access
  input wire logic i_rom_hit, // ROM hit
  input wire logic i_palette_wr, // Palette write
  input wire logic [7:0] i_palette_wdata, // Palette data
  input wire logic i_dma_want, // Bus wanted
  input wire cfg_bank_pkg::word_t o_cfg_rdata, // Read data
  input wire logic o_cfg_ack, // Ack
  input wire logic o_mem_claim, // Memory claim
  input wire logic o_rom_claim, // ROM claim
  input wire logic o_io_claim, // I/O claim
  input wire logic o_palette_claim, // Palette claim
  input wire logic o_palette_take, // Palette taken
  input wire logic [7:0] o_palette_data, // Taken data
  input wire logic o_bus_req, // Bus request
  input wire logic o_read_all_lanes, // All lanes
  input wire logic o_target_fast_chain_ok, // Target chaining
  input wire logic o_initiator_fast_chain_en, // Initiator chaining
  input wire logic o_address_stepping // Stepping
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  chk_io_silent: assert property (!o_io_claim)
    else $error("I/O access claimed");
  chk_fixed_caps: assert property (
    o_target_fast_chain_ok && !o_initiator_fast_chain_en && o_address_stepping
    && o_read_all_lanes) else $error("Fixed capability output wrong");
  chk_bus_req_src: assert property (
    o_bus_req && $past(i_clk_en) |-> $past(i_dma_want)) else $error("Unwanted bus request");
  chk_mem_claim_src: assert property (
    o_mem_claim && $past(i_clk_en) |-> $past(i_mem_req)) else $error("Memory claim uncaused");
  chk_rom_claim_src: assert property (
    o_rom_claim && $past(i_clk_en) |-> $past(i_rom_hit && i_rom_decode_en))
    else $error("ROM claim without enable");
  chk_palette_gate: assert property (
    (o_palette_take || o_palette_claim) && $past(i_clk_en)
    |-> $past(i_palette_wr && i_legacy_video_en)) else $error("Palette answered while off");
  chk_palette_data: assert property (
    o_palette_take && $past(i_clk_en) |-> o_palette_data == $past(i_palette_wdata))
    else $error("Palette data not captured");
  chk_claim_vs_take: assert property (o_palette_claim |-> o_palette_take)
    else $error("Palette claimed without taking data");
  chk_ack_timing: assert property (
    i_cfg_req && i_clk_en |=> o_cfg_ack ##1 (!o_cfg_ack || $past(i_cfg_req)))
    else $error("Config ack timing wrong");
  chk_rdata_hold: assert property (
    $past(i_clk_en) && !$past(i_sys_rst) && !$past(i_cfg_req && !i_cfg_we)
    |-> $stable(o_cfg_rdata)) else $error("Read data moved without a read");
endmodule

bind pci_cfg_command_and_base cfg_bank_asserts chk (.*);

// ===== tb/tb.sv
/*
  Self-checking bench for the command/status and window base bank.
  Assumes the host model drives the config bus and the bench the rest.
*/
`timescale 1ns/1ns

module tb;
  logic i_clk, i_sys_rst, i_clk_en, i_cfg_req, i_cfg_we, i_initiator_abort_evt;
  logic i_completer_abort_evt, i_legacy_video_en, i_rom_decode_en, i_mem_req, i_rom_hit;
  logic i_io_req, i_palette_wr, i_dma_want, o_cfg_ack, o_mem_claim, o_rom_claim, o_io_claim;
  logic o_palette_claim, o_palette_take, o_bus_req, o_read_all_lanes, o_target_fast_chain_ok;
  logic o_initiator_fast_chain_en, o_address_stepping;
  logic [7:0] i_cfg_addr, i_palette_wdata, o_palette_data;
  logic [3:0] i_cfg_be;
  logic [31:0] i_mem_addr;
  cfg_bank_pkg::word_t i_cfg_wdata, o_cfg_rdata, rd, cs_rw;
  logic [1:0] flg;
  logic [4:0] base_m;
  logic ack_m;
  logic [7:0] addrs [3] = '{8'h04, 8'h10, 8'h3C};
  int fails = 0;
  int tests_run = 0;
  int seed;

  pci_cfg_command_and_base dut (.*);
  cfg_host_model host (.i_clk(i_clk), .i_ack(o_cfg_ack), .i_rdata(o_cfg_rdata),
    .o_req(i_cfg_req), .o_we(i_cfg_we), .o_addr(i_cfg_addr), .o_be(i_cfg_be),
    .o_wdata(i_cfg_wdata));

  initial
  begin
    i_clk = 1'h0;
    forever #2 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------
  // Expectations and shared tasks
  // ----------------------------------------------------------------
  function automatic cfg_bank_pkg::word_t cs_exp();
    return 32'h02800080 | cs_rw | {2'h0, flg, 28'h0000000};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask

  task automatic cfg(input logic we, input logic [7:0] a, input logic [3:0] be,
      input cfg_bank_pkg::word_t wd);
    logic ack;
    host.access(we, a, be, wd, $urandom_range(0, 2), rd, ack);
    check("cfg_ack", ack, 1'h1);
    if (we && a == 8'h04 && be[0])
      cs_rw = wd & 32'h00000026;
    if (we && a == 8'h04 && be[3])
      flg = flg & ~wd[29:28];
    if (we && a == 8'h10 && be[3])
      base_m = wd[31:27];
  endtask

  task automatic read_all();
    cfg(1'h0, 8'h04, 4'hF, 32'h00000000);
    check("command_status", rd, cs_exp());
    cfg(1'h0, 8'h10, 4'hF, 32'h00000000);
    check("window_base", rd, {base_m, 27'h0000000} | 32'h00000008);
    cfg(1'h0, 8'h08, 4'hF, 32'h00000000);
    check("unmapped", rd, 32'h00000000);
  endtask

  task automatic reset_check();
    i_sys_rst = 1'h1;
    repeat (3) @(negedge i_clk);
    i_sys_rst = 1'h0;
    {cs_rw, flg, base_m} = {32'h00000020, 7'h00};
    cfg(1'h0, 8'h04, 4'hF, 32'h00000000);
    check("cs_reset", rd, 32'h028000A0);
    cfg(1'h0, 8'h10, 4'hF, 32'h00000000);
    check("base_reset", rd, 32'h00000008);
  endtask

  task automatic pulse(input logic [1:0] w);
    @(negedge i_clk);
    {i_initiator_abort_evt, i_completer_abort_evt} = w;
    @(negedge i_clk);
    {i_initiator_abort_evt, i_completer_abort_evt} = 2'h0;
    flg = flg | w;
  endtask

  // Enables from k, then every decode request for one cycle
  task automatic dec(input logic [3:0] k);
    cfg(1'h1, 8'h04, 4'h1, {26'h0000000, k[2], 2'h0, k[1], k[0], 1'h0});
    @(negedge i_clk);
    i_mem_addr = $urandom;
    if ($urandom_range(0, 1) == 1)
      i_mem_addr[31:27] = base_m;
    i_rom_decode_en = 1'($urandom_range(0, 1));
    i_palette_wdata = 8'($urandom);
    i_legacy_video_en = k[3];
    {i_mem_req, i_rom_hit, i_io_req, i_palette_wr, i_dma_want} = 5'h1F;
    @(negedge i_clk);
    check("mem_claim", o_mem_claim, k[0] && i_mem_addr[31:27] == base_m);
    check("rom_claim", o_rom_claim, i_rom_decode_en && k[0]);
    check("io_claim", o_io_claim, 1'h0);
    check("palette_claim", o_palette_claim, k[3] && !k[2]);
    check("palette_take", o_palette_take, k[3]);
    if (k[3])
      check("palette_data", o_palette_data, i_palette_wdata);
    check("bus_req", o_bus_req, k[1]);
    check("caps", {o_read_all_lanes, o_target_fast_chain_ok, o_initiator_fast_chain_en,
      o_address_stepping}, 4'hD);
    {i_mem_req, i_rom_hit, i_io_req, i_palette_wr, i_dma_want} = 5'h00;
  endtask

  task automatic close_out();
    $display("Checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = $urandom(40);
    i_clk_en = 1'h1;
    {i_initiator_abort_evt, i_completer_abort_evt, i_legacy_video_en, i_rom_decode_en} = 4'h0;
    {i_mem_req, i_rom_hit, i_io_req, i_palette_wr, i_dma_want} = 5'h00;
    {i_mem_addr, i_palette_wdata} = 40'h0000000000;
    reset_check();
    read_all();
    $display("Test reset values done");
    pulse(2'h3);
    read_all();
    cfg(1'h1, 8'h04, 4'h8, 32'h00000000);
    read_all();
    cfg(1'h1, 8'h04, 4'h7, 32'hFFFFFFFF);
    read_all();
    cfg(1'h1, 8'h04, 4'h8, 32'h20000000);
    read_all();
    @(negedge i_clk);
    i_clk_en = 1'h0;
    {i_initiator_abort_evt, i_completer_abort_evt} = 2'h3;
    @(negedge i_clk);
    {i_initiator_abort_evt, i_completer_abort_evt} = 2'h0;
    i_clk_en = 1'h1;
    read_all();
    // Abort event and write-one clear taken at the same edge: set wins
    fork
      pulse(2'h3);
      host.access(1'h1, 8'h04, 4'h8, 32'h30000000, 0, rd, ack_m);
    join
    check("cfg_ack", ack_m, 1'h1);
    read_all();
    $display("Test abort flags done");
    repeat (24)
    begin
      if ($urandom_range(0, 3) == 0)
        pulse(2'($urandom_range(1, 3)));
      cfg(1'h1, addrs[$urandom_range(0, 2)], 4'($urandom), $urandom);
      read_all();
    end
    $display("Test random writes done");
    for (int k = 0; k < 16; k++)
      dec(4'(k));
    $display("Test decode done");
    reset_check();
    read_all();
    $display("Test mid-run reset done");
    close_out();
  end

  initial
  begin
    #100000;
    fails++;
    close_out();
  end
endmodule
